// file: core/dcb_regs.svh
// constants for the disk control byte datapath
`ifndef DCB_REGS_SVH
`define DCB_REGS_SVH
`define DCB_UC_DEPTH   2048
`define DCB_UC_AW      11
`define DCB_UC_W       48
`define DCB_NUM_GPR    14
`define DCB_GPR_AW     4
`define DCB_CLK_NS     5
`define DCB_STEP_NS    500
`define DCB_STEP_CYC   (`DCB_STEP_NS / `DCB_CLK_NS)
`define DCB_DIV_W      7
`define DCB_BIT_CYC    8
`define DCB_BDIV_W     3
`define DCB_BYTE_BITS  4'h8
`define DCB_DES_GPR    4'h0
`define DCB_SY_W       5
`define DCB_SY_VALID   0
`define DCB_SY_READY   1
`define DCB_SY_TAKEN   2
`define DCB_SY_RCLK    3
`define DCB_SY_RBIT    4
`endif

// file: core/dcb_pkg.sv
// types for the disk control byte datapath
`include "dcb_regs.svh"
package dcb_pkg;
  typedef enum logic [2:0] {DCB_OP_PASS, DCB_OP_ADD, DCB_OP_SUB, DCB_OP_OR,
                            DCB_OP_AND, DCB_OP_XOR} dcb_op_t;
  typedef enum logic [1:0] {DCB_SRC_GPR, DCB_SRC_CHAN, DCB_SRC_CONST,
                            DCB_SRC_ZERO} dcb_src_t;
  typedef enum logic [2:0] {DCB_ACT_NONE, DCB_ACT_CHAN_REQ, DCB_ACT_CHAN_SEND,
                            DCB_ACT_SER_LOAD, DCB_ACT_DES_ACK} dcb_act_t;
  typedef enum logic [2:0] {DCB_CND_ALWAYS, DCB_CND_CHAN_BYTE, DCB_CND_DES_FULL,
                            DCB_CND_SER_IDLE, DCB_CND_CARRY} dcb_cnd_t;
  // one 48-bit control word, one microprogram step
  typedef struct packed {
    logic [4:0]            rsvd;
    logic [`DCB_UC_AW-1:0] next;
    logic [7:0]            konst;
    dcb_cnd_t              cnd;
    dcb_act_t              act;
    logic                  wr;
    dcb_src_t              asel;
    logic [3:0]            dst;
    logic [3:0]            b;
    logic [3:0]            a;
    dcb_op_t               op;
  } dcb_ctl_t;
  // byte with odd parity
  typedef struct packed {
    logic       par;
    logic [7:0] dat;
  } dcb_byte_t;
  typedef enum logic [1:0] {DCB_CI_IDLE, DCB_CI_REQ, DCB_CI_DROP} dcb_ci_t;
  typedef enum logic [1:0] {DCB_CO_IDLE, DCB_CO_AVAIL, DCB_CO_DRIVE,
                            DCB_CO_DROP} dcb_co_t;
  typedef struct packed {
    logic [`DCB_UC_DEPTH-1:0][`DCB_UC_W-1:0] ucode;
    logic [`DCB_UC_AW-1:0]                   pc;
    logic [`DCB_DIV_W-1:0]                   div;
    logic [`DCB_BDIV_W-1:0]                  bdiv;
    dcb_byte_t [`DCB_NUM_GPR-1:0]            gpr;
    logic                                    carry;
    logic [`DCB_SY_W-1:0]                    s0;
    logic [`DCB_SY_W-1:0]                    s1;
    logic [`DCB_SY_W-1:0]                    s2;
    logic [`DCB_SY_W-1:0]                    flt;
    dcb_ci_t                                 ci;
    logic                                    req;
    dcb_byte_t                               hold;
    logic                                    hold_full;
    dcb_co_t                                 co;
    logic                                    avail;
    logic                                    in_valid;
    dcb_byte_t                               bus_in;
    dcb_byte_t [1:0]                         fifo;
    logic                                    wp;
    logic                                    rp;
    logic [1:0]                              cnt;
    logic [7:0]                              ser_sh;
    logic [3:0]                              ser_n;
    logic                                    ser_busy;
    logic                                    wr_data;
    logic                                    wr_gate;
    logic [7:0]                              des_sh;
    logic [3:0]                              des_n;
    logic                                    des_full;
  } dcb_state_t;
endpackage : dcb_pkg

// file: core/dcb_datapath.sv
// byte datapath: microsequencer, alu, byte registers, channel and serial ends
`timescale 1ns/100ps
`include "dcb_regs.svh"
module dcb_datapath (
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire logic                  ucode_we,
  input  wire logic [`DCB_UC_AW-1:0] ucode_addr,
  input  wire logic [`DCB_UC_W-1:0]  ucode_data,
  input  wire dcb_pkg::dcb_byte_t    chan_bus_out,
  input  wire logic                  chan_out_valid,
  input  wire logic                  chan_in_ready,
  input  wire logic                  chan_in_taken,
  output logic                       chan_req,
  output logic                       chan_in_avail,
  output logic                       chan_in_valid,
  output dcb_pkg::dcb_byte_t         chan_bus_in,
  output logic                       dev_wr_data,
  output logic                       dev_wr_gate,
  input  wire logic                  dev_rd_clk,
  input  wire logic                  dev_rd_bit,
  output logic [`DCB_UC_AW-1:0]      useq_addr
);
  import dcb_pkg::*;

  dcb_state_t st;     // all registered state except the gap helper
  dcb_state_t n;      // next value of the state
  dcb_ctl_t   w;      // word under the program counter
  logic       tick;   // one-cycle step enable
  logic       btick;  // one-cycle bit enable
  logic       cnd_ok; // branch condition met
  logic       stall;  // back-pressure holds the step
  logic       exec;   // step executes this cycle
  logic       push;   // byte enters channel buffer
  logic       pop;    // channel took a byte
  logic       rise;   // filtered device bit clock edge
  logic [7:0] opa;    // alu operand a
  logic [7:0] opb;    // alu operand b
  logic [8:0] sum;    // alu result with carry
  dcb_byte_t  res;    // alu result with parity

  // whole next-state function
  always_comb begin
    n = st;
    w = dcb_ctl_t'(st.ucode[st.pc]);
    tick = st.div == `DCB_DIV_W'(`DCB_STEP_CYC - 1);
    n.div = tick ? '0 : st.div + `DCB_DIV_W'(1);
    btick = st.bdiv == `DCB_BDIV_W'(`DCB_BIT_CYC - 1);
    n.bdiv = btick ? '0 : st.bdiv + `DCB_BDIV_W'(1);
    // three-stage capture; level counts once stages two and three agree
    n.s0 = {dev_rd_bit, dev_rd_clk, chan_in_taken, chan_in_ready, chan_out_valid};
    n.s1 = st.s0;
    n.s2 = st.s1;
    n.flt = ((st.s1 ~^ st.s2) & st.s2) | ((st.s1 ^ st.s2) & st.flt);
    rise = n.flt[`DCB_SY_RCLK] & ~st.flt[`DCB_SY_RCLK];
    if (ucode_we) begin
      n.ucode[ucode_addr] = ucode_data;
    end
    opb = (w.b < `DCB_GPR_AW'(`DCB_NUM_GPR)) ? st.gpr[w.b].dat : 8'h00;
    case (w.asel)
      DCB_SRC_GPR:   opa = (w.a < `DCB_GPR_AW'(`DCB_NUM_GPR)) ? st.gpr[w.a].dat : 8'h00;
      DCB_SRC_CHAN:  opa = st.hold.dat;
      DCB_SRC_CONST: opa = w.konst;
      default:       opa = 8'h00;
    endcase
    case (w.op)
      DCB_OP_PASS: sum = {1'b0, opa};
      DCB_OP_ADD:  sum = {1'b0, opa} + {1'b0, opb};
      DCB_OP_SUB:  sum = {1'b0, opa} - {1'b0, opb};
      DCB_OP_OR:   sum = {1'b0, opa | opb};
      DCB_OP_AND:  sum = {1'b0, opa & opb};
      DCB_OP_XOR:  sum = {1'b0, opa ^ opb};
      default:     sum = {1'b0, opa};
    endcase
    // parity regenerated on every alu pass
    res.dat = sum[7:0];
    // odd parity: bit set when the byte has an even count of ones
    res.par = ~^sum[7:0];
    case (w.cnd)
      DCB_CND_ALWAYS:    cnd_ok = 1'b1;
      DCB_CND_CHAN_BYTE: cnd_ok = st.hold_full;
      DCB_CND_DES_FULL:  cnd_ok = st.des_full;
      DCB_CND_SER_IDLE:  cnd_ok = ~st.ser_busy;
      DCB_CND_CARRY:     cnd_ok = st.carry;
      default:           cnd_ok = 1'b1;
    endcase
    // actions that cannot proceed hold the step rather than drop data
    case (w.act)
      DCB_ACT_CHAN_REQ:  stall = (st.ci != DCB_CI_IDLE) | st.hold_full;
      DCB_ACT_CHAN_SEND: stall = st.cnt[1];
      DCB_ACT_SER_LOAD:  stall = st.ser_busy;
      default:           stall = 1'b0;
    endcase
    exec = tick & cnd_ok & ~stall;
    // sequencer waits on an unmet condition
    if (exec) begin
      n.pc = w.next;
    end
    if (exec && w.wr && (w.dst < `DCB_GPR_AW'(`DCB_NUM_GPR))) begin
      n.gpr[w.dst] = res;
    end
    if (exec && ((w.op == DCB_OP_ADD) || (w.op == DCB_OP_SUB))) begin
      n.carry = sum[8];
    end
    // consuming the channel byte frees the holding register
    if (exec && (w.asel == DCB_SRC_CHAN)) begin
      n.hold_full = 1'b0;
    end
    // channel write side
    case (st.ci)
      DCB_CI_IDLE: begin
        if (exec && (w.act == DCB_ACT_CHAN_REQ)) begin
          n.req = 1'b1;
          n.ci = DCB_CI_REQ;
        end
      end
      DCB_CI_REQ: begin
        // byte is stable once valid is seen
        if (st.flt[`DCB_SY_VALID]) begin
          n.hold = chan_bus_out;
          n.hold_full = 1'b1;
          n.req = 1'b0;
          n.ci = DCB_CI_DROP;
        end
      end
      DCB_CI_DROP: begin
        // wait for valid to fall before the next request
        if (!st.flt[`DCB_SY_VALID]) begin
          n.ci = DCB_CI_IDLE;
        end
      end
      default: n.ci = DCB_CI_IDLE;
    endcase
    // two-entry buffer toward the channel
    push = exec & (w.act == DCB_ACT_CHAN_SEND);
    pop = (st.co == DCB_CO_DRIVE) & st.flt[`DCB_SY_TAKEN];
    if (push) begin
      n.fifo[st.wp] = (w.a < `DCB_GPR_AW'(`DCB_NUM_GPR)) ? st.gpr[w.a] : '0;
      n.wp = ~st.wp;
    end
    if (pop) begin
      n.rp = ~st.rp;
    end
    n.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
    // channel read side
    case (st.co)
      DCB_CO_IDLE: begin
        if (st.cnt != 2'h0) begin
          n.avail = 1'b1;
          n.co = DCB_CO_AVAIL;
        end
      end
      DCB_CO_AVAIL: begin
        if (st.flt[`DCB_SY_READY]) begin
          n.bus_in = st.fifo[st.rp];
          n.in_valid = 1'b1;
          n.co = DCB_CO_DRIVE;
        end
      end
      DCB_CO_DRIVE: begin
        if (st.flt[`DCB_SY_TAKEN]) begin
          n.in_valid = 1'b0;
          n.avail = 1'b0;
          n.co = DCB_CO_DROP;
        end
      end
      DCB_CO_DROP: begin
        if (!st.flt[`DCB_SY_TAKEN] && !st.flt[`DCB_SY_READY]) begin
          n.co = DCB_CO_IDLE;
        end
      end
      default: n.co = DCB_CO_IDLE;
    endcase
    // serializer shifts msb first on its own bit pace
    if (btick && st.ser_busy) begin
      if (st.ser_n != 4'h0) begin
        n.wr_data = st.ser_sh[7];
        n.ser_sh = {st.ser_sh[6:0], 1'b0};
        n.ser_n = st.ser_n - 4'h1;
        n.wr_gate = 1'b1;
      end else begin
        n.ser_busy = 1'b0;
        n.wr_gate = 1'b0;
      end
    end
    if (exec && (w.act == DCB_ACT_SER_LOAD)) begin
      n.ser_sh = opa;
      n.ser_n = `DCB_BYTE_BITS;
      n.ser_busy = 1'b1;
    end
    // acknowledge first so a new byte in the same cycle still sets the flag
    if (exec && (w.act == DCB_ACT_DES_ACK)) begin
      n.des_full = 1'b0;
    end
    // deserializer assembles on filtered clock edges
    if (rise) begin
      n.des_sh = {st.des_sh[6:0], st.flt[`DCB_SY_RBIT]};
      n.des_n = st.des_n + 4'h1;
      // full byte into the fixed register, flag raised
      if (st.des_n == `DCB_BYTE_BITS - 4'h1) begin
        n.des_n = 4'h0;
        n.gpr[`DCB_DES_GPR] = {~^{st.des_sh[6:0], st.flt[`DCB_SY_RBIT]},
                               st.des_sh[6:0], st.flt[`DCB_SY_RBIT]};
        n.des_full = 1'b1;
      end
    end
  end

  // single state register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= n;
    end
  end

  // outputs straight from the state register
  assign chan_req      = st.req;
  assign chan_in_avail = st.avail;
  assign chan_in_valid = st.in_valid;
  assign chan_bus_in   = st.bus_in;
  assign dev_wr_data   = st.wr_data;
  assign dev_wr_gate   = st.wr_gate;
  assign useq_addr     = st.pc;

  // helper: cycles since last step tick
  logic [7:0] gap;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gap <= 8'h00;
    end else begin
      gap <= tick ? 8'h00 : gap + 8'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // every tick lands one full step after the one before
  AST_STEP_PACE: assert property (tick |-> gap == 8'(`DCB_STEP_CYC - 1))
    else $error("step spacing is not 500 ns");
  // channel byte reaches its register untouched
  AST_PASS_CHAN: assert property (exec && w.op == DCB_OP_PASS && w.asel == DCB_SRC_CHAN
    && w.wr && w.dst != `DCB_DES_GPR && w.dst < 4'he && !rise
    |=> st.gpr[$past(w.dst)].dat == $past(st.hold.dat))
    else $error("channel byte altered on its way to a register");
  // register to register add, the form the microprogram really uses
  AST_ADD: assert property (exec && w.op == DCB_OP_ADD && w.asel == DCB_SRC_GPR
    && w.wr && w.dst != `DCB_DES_GPR && w.dst < 4'he && w.a < 4'he && w.b < 4'he
    |=> st.gpr[$past(w.dst)].dat == 8'($past(st.gpr[w.a].dat) + $past(st.gpr[w.b].dat)))
    else $error("add result wrong");
  // every stored alu result carries odd parity
  AST_GPR_PAR: assert property (exec && w.wr && w.dst < 4'he
    |=> ^st.gpr[$past(w.dst)] == 1'b1)
    else $error("register byte without odd parity");
  AST_BUS_PAR: assert property (chan_in_valid |-> ^chan_bus_in == 1'b1)
    else $error("bus in byte without odd parity");
  AST_REQ_FIRST: assert property ($rose(st.hold_full) |-> $past(chan_req))
    else $error("channel byte taken without request");
  AST_DRIVE_AFTER: assert property ($rose(chan_in_valid)
    |-> $past(chan_in_avail) && $past(st.flt[`DCB_SY_READY]))
    else $error("bus in driven before ready");
  AST_SER_DONE: assert property (exec && w.act == DCB_ACT_SER_LOAD
    |=> st.ser_busy ##[60:90] !st.ser_busy)
    else $error("serializer did not finish eight bits");
  AST_DES_BYTE: assert property (rise && st.des_n == 4'h7
    |=> st.des_full && st.gpr[`DCB_DES_GPR].dat == $past({st.des_sh[6:0],
        st.flt[`DCB_SY_RBIT]}))
    else $error("assembled byte not delivered");
  AST_HOLD_PC: assert property (tick && !cnd_ok |=> $stable(st.pc))
    else $error("step advanced on unmet condition");

  COV_WRITE_PATH: cover property (exec && w.act == DCB_ACT_SER_LOAD);
  COV_READ_PATH: cover property ($rose(chan_in_valid));
  COV_BUF_FULL: cover property (st.cnt == 2'h2);
  COV_DES_FLAG: cover property ($rose(st.des_full));
  // back-pressure holding a step
  COV_STEP_STALL: cover property (tick && stall);
endmodule : dcb_datapath

// file: dv/dcb_chan_model.sv
// host channel partner model: outbound bytes on request, inbound bytes taken
`timescale 1ns/100ps
module dcb_chan_model (
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic               slow,
  input  wire dcb_pkg::dcb_byte_t out_byte,
  input  wire logic               chan_req,
  input  wire logic               chan_in_avail,
  input  wire logic               chan_in_valid,
  input  wire dcb_pkg::dcb_byte_t chan_bus_in,
  output dcb_pkg::dcb_byte_t      chan_bus_out,
  output logic                    chan_out_valid,
  output logic                    chan_in_ready,
  output logic                    chan_in_taken,
  output logic                    got,
  output dcb_pkg::dcb_byte_t      got_byte,
  output logic                    out_done
);
  import dcb_pkg::*;
  // outbound side; slow mode lets the request hang a long while
  initial begin
    int dly;
    chan_bus_out = '0;
    chan_out_valid = 1'b0;
    out_done = 1'b0;
    forever begin
      @(posedge mclk);
      if (rst_b && chan_req) begin
        dly = slow ? 230 : 3;
        repeat (dly) @(posedge mclk);
        chan_bus_out <= out_byte;
        @(posedge mclk);
        chan_out_valid <= 1'b1;
        while (chan_req) @(posedge mclk);
        chan_out_valid <= 1'b0;
        // released bus shows garbage, not the old byte
        chan_bus_out <= ~out_byte;
        out_done <= 1'b1;
        @(posedge mclk);
        out_done <= 1'b0;
      end
    end
  end
  // inbound side; a slow channel lets the two-entry buffer fill
  initial begin
    int dly;
    chan_in_ready = 1'b0;
    chan_in_taken = 1'b0;
    got = 1'b0;
    got_byte = '0;
    forever begin
      @(posedge mclk);
      if (rst_b && chan_in_avail) begin
        dly = slow ? 230 : 3;
        repeat (dly) @(posedge mclk);
        chan_in_ready <= 1'b1;
        while (!chan_in_valid) @(posedge mclk);
        got_byte <= chan_bus_in;
        got <= 1'b1;
        chan_in_taken <= 1'b1;
        @(posedge mclk);
        got <= 1'b0;
        while (chan_in_valid) @(posedge mclk);
        chan_in_ready <= 1'b0;
        chan_in_taken <= 1'b0;
        @(posedge mclk);
      end
    end
  end
endmodule : dcb_chan_model

// file: dv/tb_disk_control_byte_datapath.sv
// self-checking bench: write path, alu ops, serial ends, read path
`timescale 1ns/100ps
module tb_disk_control_byte_datapath;
  import dcb_pkg::*;
  logic               mclk = 1'b0;
  logic               rst_b = 1'b0;
  logic               ucode_we = 1'b0;
  logic [10:0]        ucode_addr = '0;
  logic [47:0]        ucode_data = '0;
  logic               dev_rd_clk = 1'b0;
  logic               dev_rd_bit = 1'b0;
  logic               slow = 1'b0;
  dcb_byte_t          out_byte = '0;
  dcb_byte_t          k_cur, chan_bus_out, chan_bus_in, got_byte;
  logic               chan_out_valid, chan_in_ready, chan_in_taken, got, out_done;
  logic               chan_req, chan_in_avail, chan_in_valid, dev_wr_data, dev_wr_gate;
  logic [10:0]        useq_addr, last_pc;
  logic [31:0]        seed = 32'h99db;
  logic [7:0]         w, k, r, sw;
  dcb_byte_t          exp_q[$];
  logic [7:0]         ser_q[$];
  dcb_op_t            ops[5] = '{DCB_OP_ADD, DCB_OP_SUB, DCB_OP_OR, DCB_OP_AND, DCB_OP_XOR};
  int                 fails = 0;
  int                 n_compared = 0;
  int                 cyc = 0;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  dcb_datapath i_dut (.mclk(mclk), .rst_b(rst_b), .ucode_we(ucode_we), .ucode_addr(ucode_addr),
    .ucode_data(ucode_data), .chan_bus_out(chan_bus_out), .chan_out_valid(chan_out_valid),
    .chan_in_ready(chan_in_ready), .chan_in_taken(chan_in_taken), .chan_req(chan_req),
    .chan_in_avail(chan_in_avail), .chan_in_valid(chan_in_valid), .chan_bus_in(chan_bus_in),
    .dev_wr_data(dev_wr_data), .dev_wr_gate(dev_wr_gate), .dev_rd_clk(dev_rd_clk),
    .dev_rd_bit(dev_rd_bit), .useq_addr(useq_addr));
  dcb_chan_model i_chan (.mclk(mclk), .rst_b(rst_b), .slow(slow), .out_byte(out_byte),
    .chan_req(chan_req), .chan_in_avail(chan_in_avail), .chan_in_valid(chan_in_valid),
    .chan_bus_in(chan_bus_in), .chan_bus_out(chan_bus_out), .chan_out_valid(chan_out_valid),
    .chan_in_ready(chan_in_ready), .chan_in_taken(chan_in_taken), .got(got),
    .got_byte(got_byte), .out_done(out_done));
  // one comparison, counted
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // verdict and end of run
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // expected alu result with odd parity
  function automatic dcb_byte_t ex(input dcb_op_t op, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] q;
    case (op)
      DCB_OP_ADD: q = a + b;
      DCB_OP_SUB: q = a - b;
      DCB_OP_OR:  q = a | b;
      DCB_OP_AND: q = a & b;
      default:    q = a ^ b;
    endcase
    return {~^q, q};
  endfunction : ex
  function automatic logic [47:0] uw(dcb_op_t op, logic [3:0] a, logic [3:0] b, logic [3:0] d,
    dcb_src_t s, logic wr, dcb_act_t act, dcb_cnd_t cnd, logic [10:0] nx);
    dcb_ctl_t c;
    c = '{rsvd:5'h0, next:nx, konst:8'h0, cnd:cnd, act:act, wr:wr, asel:s, dst:d, b:b, a:a,
      op:op};
    return c;
  endfunction : uw
  // one store word per edge, back to back
  task automatic load(input logic [10:0] ad, input logic [47:0] wd);
    ucode_addr <= ad;
    ucode_data <= wd;
    ucode_we <= 1'b1;
    @(posedge mclk);
  endtask : load
  // serial read byte, msb first, bit steady around clock rise
  task automatic rd_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      dev_rd_bit <= b[i];
      repeat (8) @(posedge mclk);
      dev_rd_clk <= 1'b1;
      repeat (8) @(posedge mclk);
      dev_rd_clk <= 1'b0;
    end
    dev_rd_bit <= ~b[0];
  endtask : rd_byte
  // second channel byte follows the first
  always @(posedge mclk) if (out_done) out_byte <= k_cur;
  // inbound bytes in order with odd parity
  always @(negedge mclk) if (got === 1'b1)
    chk("bus_in", {2'h0, exp_q.size() ? exp_q.pop_front() : 9'h1ff},
      {2'h0, got_byte});
  // pc moves only on the step pace, so every gap is whole steps of 100 cycles
  always @(negedge mclk) begin
    cyc++;
    if (rst_b && useq_addr !== last_pc) begin
      if (last_pc !== 11'h0) chk("step_gap", 11'h0, 11'(cyc % 100));
      cyc = 0;
    end
    last_pc = useq_addr;
  end
  // serial write stream, sampled mid-bit
  initial begin
    forever begin
      @(negedge mclk);
      if (dev_wr_gate === 1'b1) begin
        sw = ser_q.size() ? ser_q.pop_front() : 8'h0;
        repeat (3) @(negedge mclk);
        for (int j = 7; j >= 0; j--) begin
          chk("ser_bit", {10'h0, sw[j]}, {10'h0, dev_wr_data});
          repeat (8) @(negedge mclk);
        end
        while (dev_wr_gate === 1'b1) @(negedge mclk);
      end
    end
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    finish_test();
  end
  initial begin
    int n;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk("idle_out", 11'h0, {chan_req, chan_in_avail, chan_in_valid, dev_wr_gate,
      useq_addr[6:0]});
    @(posedge mclk);
    // write path, alu ops, read path as one looping program
    load(11'h0, uw(DCB_OP_PASS, 4'h0, 4'h0, 4'h0, DCB_SRC_GPR, 1'b0,
      DCB_ACT_CHAN_REQ, DCB_CND_ALWAYS, 11'h1));
    load(11'h1, uw(DCB_OP_PASS, 4'h0, 4'h0, 4'h1, DCB_SRC_CHAN, 1'b1,
      DCB_ACT_NONE, DCB_CND_CHAN_BYTE, 11'h2));
    load(11'h2, uw(DCB_OP_PASS, 4'h0, 4'h0, 4'h0, DCB_SRC_GPR, 1'b0,
      DCB_ACT_CHAN_REQ, DCB_CND_ALWAYS, 11'h3));
    load(11'h3, uw(DCB_OP_PASS, 4'h0, 4'h0, 4'h3, DCB_SRC_CHAN, 1'b1,
      DCB_ACT_NONE, DCB_CND_CHAN_BYTE, 11'h4));
    load(11'h4, uw(DCB_OP_PASS, 4'h1, 4'h0, 4'h0, DCB_SRC_GPR, 1'b0,
      DCB_ACT_SER_LOAD, DCB_CND_ALWAYS, 11'h5));
    load(11'h5, uw(DCB_OP_PASS, 4'h1, 4'h0, 4'h0, DCB_SRC_GPR, 1'b0,
      DCB_ACT_CHAN_SEND, DCB_CND_ALWAYS, 11'h6));
    for (int i = 0; i < 5; i++) begin
      load(11'(6 + 2 * i), uw(ops[i], 4'h1, 4'h3, 4'h4, DCB_SRC_GPR, 1'b1,
        DCB_ACT_NONE, DCB_CND_ALWAYS, 11'(7 + 2 * i)));
      load(11'(7 + 2 * i), uw(DCB_OP_PASS, 4'h4, 4'h0, 4'h0, DCB_SRC_GPR, 1'b0,
        DCB_ACT_CHAN_SEND, DCB_CND_ALWAYS, 11'(8 + 2 * i)));
    end
    load(11'h10, uw(DCB_OP_PASS, 4'h0, 4'h0, 4'h5, DCB_SRC_GPR, 1'b1,
      DCB_ACT_DES_ACK, DCB_CND_DES_FULL, 11'h11));
    load(11'h11, uw(DCB_OP_PASS, 4'h5, 4'h0, 4'h0, DCB_SRC_GPR, 1'b0,
      DCB_ACT_CHAN_SEND, DCB_CND_ALWAYS, 11'h12));
    // park until the next read byte lands, so a slow channel cannot let the
    // loop ask for a write byte before the bench has staged it
    load(11'h12, uw(DCB_OP_PASS, 4'h0, 4'h0, 4'h0, DCB_SRC_GPR, 1'b0,
      DCB_ACT_NONE, DCB_CND_DES_FULL, 11'h0));
    ucode_we <= 1'b0;
    // corner bytes first, then random; odd passes stall the channel
    for (int it = 0; it < 16; it++) begin
      seed = xs(seed);
      w = (it == 0) ? 8'h00 : (it == 1) ? 8'hff : seed[7:0];
      k = (it == 0) ? 8'hff : (it == 1) ? 8'h01 : seed[15:8];
      r = seed[23:16];
      slow <= it[0];
      out_byte <= {~^w, w};
      k_cur = {~^k, k};
      exp_q.push_back(ex(DCB_OP_OR, w, w));
      foreach (ops[i]) exp_q.push_back(ex(ops[i], w, k));
      exp_q.push_back(ex(DCB_OP_OR, r, r));
      ser_q.push_back(w);
      rd_byte(r);
      n = 0;
      while ((exp_q.size() != 0 || ser_q.size() != 0) && n < 6000) begin
        @(posedge mclk);
        n++;
      end
      chk("drained", 11'h0, 11'(exp_q.size() + ser_q.size()));
    end
    finish_test();
  end
endmodule : tb_disk_control_byte_datapath
